/* File: logic/scs_clock_ctrl.sv */
// system clock source selection, prescaling and failure monitoring
`timescale 1ns/1ps
`default_nettype none
// Function
// - reset disables every clock source except the ultra low power and 2MHz ones.
// - after reset the system clock always runs from the 2MHz oscillator.
// - calibration loop and PLL stay off after reset until enabled.
// - source selection and prescaler may be rewritten at any time.
// - source changes gate the clock so no partial pulse escapes.
// - monitored oscillator or PLL failure raises NMI, falls back internally.
// - PLL lock and lock loss or oscillator failure detected, NMI optional.
// - ultra low power oscillator gives a divided 1kHz output too.
// - ultra low power oscillator runs only while something uses it.
// - real-time counter may choose the ultra low power oscillator.
// - calibrated 32.768kHz oscillator gives full rate and 1.024kHz outputs.
// - production calibration value for it, overwritable by software.
// - 32.768kHz crystal serves system clock, counter and loop reference.
// - high frequency crystal oscillator has four range modes.
// - enabled loop keeps trimming the 2MHz oscillator calibration.
// - 32MHz oscillator tunable by software across 30 to 55MHz.
// - crystal input pin can take an external clock instead.
// - PLL multiplies by a software factor from 1 to 31.
// - prescaler divides the selected source by 1 up to 2048.
// - fast peripheral clocks run at two and four times CPU rate.
// - power reduction bit stops a chosen peripheral clock.
module scs_clock_ctrl #(
  parameter logic [6:0] CAL2M_PROD = 7'h40,
  parameter logic [6:0] CAL32M_PROD = 7'h40,
  parameter logic [7:0] CAL32K_PROD = 8'h80
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire scs_pkg::scs_axi_req_t axiReq,
  output var scs_pkg::scs_axi_rsp_t axiRsp,
  input wire logic [5:0] oscRdy,
  input wire logic xoscFail,
  input wire logic ulpTick,
  input wire logic rc32kTick,
  input wire logic rc2mTick,
  input wire logic lowFreqCrystalTick,
  input wire logic wdtUsesUlp,
  output var scs_pkg::scs_oscctl_t oscCtl,
  output var scs_pkg::scs_ticks_t ticks
);
  import scs_pkg::*;

  typedef struct packed {
    scs_oscctl_t ctl;
    scs_ticks_t tk;
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
    scs_sw_t fsm;
    logic [2:0] req;
    logic [2:0] tgt;
    logic [2:0] gapCnt;
    logic fallback;
    logic [3:0] divExp;
    logic [12:0] divCnt;
    logic [4:0] ulpCnt;
    logic [4:0] rcCnt;
    logic dfllEn;
    logic dfllRef;
    logic [7:0] dfllTarget;
    logic [7:0] dfllCnt;
    logic monEn;
    logic lockNmiEn;
    logic xFailFlag;
    logic pllFailFlag;
    logic lockFlag;
    logic awGot;
    logic wGot;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    scs_axi_rsp_t rsp;
  } scs_state_t;

  // only the low power oscillator kept, plus the default 2MHz
  localparam scs_oscctl_t CTL_RST = '{
    oscEn: 6'h01, ulpEn: 1'b1, sysSel: SRC_RC2M, clkHold: 1'b0,
    pllFactor: PLL_FACTOR_RST, pllSrc: PLLSRC_RC2M, xoscRange: 2'h0,
    crystalInputExtClk: 1'b0, lowFreqCrystalLowPwr: 1'b0,
    rtcSel: RTC_ULP1K, cal2m: CAL2M_PROD, cal32m: CAL32M_PROD,
    cal32k: CAL32K_PROD, periphClkEn: 8'hFF};
  localparam scs_axi_rsp_t RSP_RST = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
  localparam scs_state_t ST_RST = '{
    ctl: CTL_RST, rsp: RSP_RST, fsm: SW_IDLE, req: SRC_RC2M,
    tgt: SRC_RC2M, dfllTarget: FREQUENCY_LOCKED_CALIBRATOR_TARGET_RST, default: '0};

  scs_state_t st_ff;
  scs_state_t nxt_st;
  logic [IN_W-1:0] rawIn;
  logic [IN_W-1:0] rise;
  logic [IN_W-1:0] fall;
  logic [5:0] okVec;
  logic reqOk;

  function automatic logic [12:0] divMask(input logic [3:0] e);
    divMask = 13'((14'h1 << e) - 14'h1);
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= OFF_PR);
  endfunction

  function automatic logic [31:0] regRead(input logic [7:0] a,
                                          input scs_state_t s);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      OFF_SYS: begin
        r[2:0] = s.req;
        r[SYS_ACT_LSB +: 3] = s.ctl.sysSel;
        r[SYS_HOLD_BIT] = s.ctl.clkHold;
      end
      OFF_OSC: begin
        r[5:0] = s.ctl.oscEn;
        r[OSC_RDY_LSB +: 6] = s.s2[5:0];
        r[OSC_ULP_BIT] = s.ctl.ulpEn;
      end
      OFF_XOSC: begin
        r[1:0] = s.ctl.xoscRange;
        r[XOSC_EXT_BIT] = s.ctl.crystalInputExtClk;
        r[XOSC_LP_BIT] = s.ctl.lowFreqCrystalLowPwr;
      end
      OFF_PLL: begin
        r[4:0] = s.ctl.pllFactor;
        r[PLL_SRC_LSB +: 2] = s.ctl.pllSrc;
      end
      OFF_PRESC: r[3:0] = s.divExp;
      OFF_RTC: r[2:0] = s.ctl.rtcSel;
      OFF_FREQUENCY_LOCKED_CALIBRATOR: begin
        r[0] = s.dfllEn;
        r[FREQUENCY_LOCKED_CALIBRATOR_REF_BIT] = s.dfllRef;
        r[FREQUENCY_LOCKED_CALIBRATOR_TGT_LSB +: 8] = s.dfllTarget;
      end
      OFF_CAL: begin
        r[6:0] = s.ctl.cal2m;
        r[CAL_32M_LSB +: 7] = s.ctl.cal32m;
        r[CAL_32K_LSB +: 8] = s.ctl.cal32k;
      end
      OFF_FAIL: begin
        r[0] = s.monEn;
        r[FAIL_LNMI_BIT] = s.lockNmiEn;
        r[FAIL_XF_BIT] = s.xFailFlag;
        r[FAIL_PF_BIT] = s.pllFailFlag;
        r[FAIL_LK_BIT] = s.lockFlag;
      end
      OFF_PR: r[7:0] = ~s.ctl.periphClkEn;
      default: r = 32'h0;
    endcase
    regRead = r;
  endfunction

  assign rawIn = {lowFreqCrystalTick, rc2mTick, rc32kTick, ulpTick,
                  xoscFail, oscRdy};
  // s1 is read only by s2; edges come from the settled s2/s3 pair
  assign rise = st_ff.s2 & ~st_ff.s3;
  assign fall = ~st_ff.s2 & st_ff.s3;
  assign okVec = st_ff.ctl.oscEn & st_ff.s2[5:0];
  assign reqOk = okVec[st_ff.req];

  always_comb begin
    logic [31:0] w;
    logic [31:0] bm;
    logic refEdge;
    logic fail;
    w = 32'h0;
    bm = 32'h0;
    refEdge = 1'b0;
    fail = 1'b0;
    nxt_st = st_ff;
    nxt_st.s1 = rawIn;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.tk.nmi = 1'b0;

    // free counter, masks pick the division ratio
    nxt_st.divCnt = st_ff.divCnt + 13'h1;
    // cpu tick at a quarter, peripheral x2 at a half
    nxt_st.tk.per4En =
      (st_ff.divCnt & divMask(st_ff.divExp)) == divMask(st_ff.divExp);
    nxt_st.tk.per2En = (st_ff.divCnt & divMask(4'(st_ff.divExp + 4'h1)))
                       == divMask(4'(st_ff.divExp + 4'h1));
    nxt_st.tk.cpuEn = (st_ff.divCnt & divMask(4'(st_ff.divExp + 4'h2)))
                      == divMask(4'(st_ff.divExp + 4'h2));

    // low frequency sources divided by 32
    nxt_st.tk.ulp32k = rise[IN_ULP];
    nxt_st.tk.ulp1k = rise[IN_ULP] && st_ff.ulpCnt == LF_DIV_LAST;
    nxt_st.tk.rc32kOut = rise[IN_RC32K];
    nxt_st.tk.rc1kOut = rise[IN_RC32K] && st_ff.rcCnt == LF_DIV_LAST;
    if (rise[IN_ULP]) begin
      nxt_st.ulpCnt = st_ff.ulpCnt + 5'h1;
    end
    if (rise[IN_RC32K]) begin
      nxt_st.rcCnt = st_ff.rcCnt + 5'h1;
    end

    // low power oscillator follows its users
    nxt_st.ctl.ulpEn = wdtUsesUlp || st_ff.ctl.rtcSel == RTC_ULP1K
                       || st_ff.ctl.rtcSel == RTC_ULP32K;

    // count 2MHz edges per reference edge, trim toward target
    // the 32.768kHz crystal may serve as reference
    refEdge = st_ff.dfllRef ? rise[IN_X32K] : rise[IN_RC32K];
    if (st_ff.dfllEn) begin
      if (rise[IN_RC2M] && st_ff.dfllCnt != 8'hFF) begin
        nxt_st.dfllCnt = st_ff.dfllCnt + 8'h1;
      end
      if (refEdge) begin
        nxt_st.dfllCnt = 8'h0;
        if (st_ff.dfllCnt > st_ff.dfllTarget
            && st_ff.ctl.cal2m != 7'h00) begin
          nxt_st.ctl.cal2m = st_ff.ctl.cal2m - 7'h1;
        end else if (st_ff.dfllCnt < st_ff.dfllTarget
                     && st_ff.ctl.cal2m != 7'h7F) begin
          nxt_st.ctl.cal2m = st_ff.ctl.cal2m + 7'h1;
        end
      end
    end

    // bus: address and data taken in either order, one write at a time
    if (st_ff.rsp.bvalid && axiReq.bready) begin
      nxt_st.rsp.bvalid = 1'b0;
    end
    if (st_ff.rsp.rvalid && axiReq.rready) begin
      nxt_st.rsp.rvalid = 1'b0;
    end
    if (axiReq.awvalid && st_ff.rsp.awready) begin
      nxt_st.awGot = 1'b1;
      nxt_st.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_ff.rsp.wready) begin
      nxt_st.wGot = 1'b1;
      nxt_st.wData = axiReq.wdata;
      nxt_st.wStrb = axiReq.wstrb;
    end
    if (nxt_st.awGot && nxt_st.wGot && !nxt_st.rsp.bvalid) begin
      nxt_st.awGot = 1'b0;
      nxt_st.wGot = 1'b0;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp = isMapped(nxt_st.awAddr) ? RESP_OK : RESP_SLVERR;
      bm = {{8{nxt_st.wStrb[3]}}, {8{nxt_st.wStrb[2]}},
            {8{nxt_st.wStrb[1]}}, {8{nxt_st.wStrb[0]}}};
      w = (regRead(nxt_st.awAddr, st_ff) & ~bm) | (nxt_st.wData & bm);
      case (nxt_st.awAddr)
        // selection may be rewritten at any time
        OFF_SYS: begin
          if (w[2:0] < 3'(NSRC)) begin
            nxt_st.req = w[2:0];
          end
        end
        OFF_OSC: begin
          nxt_st.ctl.oscEn = w[5:0];
          // the running source cannot be switched off under the cpu
          nxt_st.ctl.oscEn[st_ff.ctl.sysSel] = 1'b1;
        end
        // range mode and external clock on the input pin
        OFF_XOSC: begin
          nxt_st.ctl.xoscRange = w[1:0];
          nxt_st.ctl.crystalInputExtClk = w[XOSC_EXT_BIT];
          nxt_st.ctl.lowFreqCrystalLowPwr = w[XOSC_LP_BIT];
        end
        // factor zero is refused, old factor kept
        OFF_PLL: begin
          if (w[4:0] != 5'h00) begin
            nxt_st.ctl.pllFactor = w[4:0];
          end
          if (w[PLL_SRC_LSB +: 2] != 2'h3) begin
            nxt_st.ctl.pllSrc = w[PLL_SRC_LSB +: 2];
          end
        end
        OFF_PRESC: begin
          if (w[3:0] <= DIV_EXP_MAX) begin
            nxt_st.divExp = w[3:0];
          end
        end
        OFF_RTC: begin
          if (w[2:0] <= RTC_RC32K) begin
            nxt_st.ctl.rtcSel = w[2:0];
          end
        end
        OFF_FREQUENCY_LOCKED_CALIBRATOR: begin
          nxt_st.dfllEn = w[0];
          nxt_st.dfllRef = w[FREQUENCY_LOCKED_CALIBRATOR_REF_BIT];
          nxt_st.dfllTarget = w[FREQUENCY_LOCKED_CALIBRATOR_TGT_LSB +: 8];
        end
        OFF_CAL: begin
          nxt_st.ctl.cal2m = w[6:0];
          nxt_st.ctl.cal32m = w[CAL_32M_LSB +: 7];
          nxt_st.ctl.cal32k = w[CAL_32K_LSB +: 8];
        end
        OFF_FAIL: begin
          nxt_st.monEn = w[0];
          nxt_st.lockNmiEn = w[FAIL_LNMI_BIT];
          if (nxt_st.wData[FAIL_XF_BIT] && nxt_st.wStrb[1]) begin
            nxt_st.xFailFlag = 1'b0;
          end
          if (nxt_st.wData[FAIL_PF_BIT] && nxt_st.wStrb[1]) begin
            nxt_st.pllFailFlag = 1'b0;
          end
          if (nxt_st.wData[FAIL_LK_BIT] && nxt_st.wStrb[1]) begin
            nxt_st.lockFlag = 1'b0;
          end
        end
        // set bit stops that peripheral clock
        OFF_PR: nxt_st.ctl.periphClkEn = ~w[7:0];
        default: nxt_st.rsp.bresp = RESP_SLVERR;
      endcase
    end
    if (axiReq.arvalid && st_ff.rsp.arready) begin
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata = regRead(axiReq.araddr, st_ff);
      nxt_st.rsp.rresp = isMapped(axiReq.araddr) ? RESP_OK : RESP_SLVERR;
    end
    nxt_st.rsp.awready = !nxt_st.awGot && !nxt_st.rsp.bvalid;
    nxt_st.rsp.wready = !nxt_st.wGot && !nxt_st.rsp.bvalid;
    nxt_st.rsp.arready = !nxt_st.rsp.rvalid;

    // clock held low a gap before and after the select moves
    case (st_ff.fsm)
      SW_IDLE: begin
        // wait until the requested source is up
        if (st_ff.req != st_ff.ctl.sysSel && reqOk) begin
          nxt_st.fsm = SW_STOP;
          nxt_st.tgt = st_ff.req;
          nxt_st.ctl.clkHold = 1'b1;
          nxt_st.gapCnt = 3'h0;
          nxt_st.fallback = 1'b0;
        end
      end
      SW_STOP: begin
        nxt_st.gapCnt = st_ff.gapCnt + 3'h1;
        if (st_ff.gapCnt == SWITCH_GAP_CYC - 3'h1) begin
          nxt_st.ctl.sysSel = st_ff.tgt;
          nxt_st.gapCnt = 3'h0;
          nxt_st.fsm = SW_RESTART;
        end
      end
      SW_RESTART: begin
        nxt_st.gapCnt = st_ff.gapCnt + 3'h1;
        if (st_ff.gapCnt == SWITCH_GAP_CYC - 3'h1) begin
          nxt_st.ctl.clkHold = 1'b0;
          nxt_st.fallback = 1'b0;
          nxt_st.fsm = SW_IDLE;
        end
      end
      default: begin
        nxt_st.fsm = SW_IDLE;
        nxt_st.ctl.clkHold = 1'b0;
      end
    endcase

    // lock, lock loss and crystal failure; sets win over clears
    if (rise[SRC_PLL] && st_ff.ctl.oscEn[SRC_PLL]) begin
      nxt_st.lockFlag = 1'b1;
      nxt_st.tk.nmi = st_ff.lockNmiEn;
    end
    if (fall[SRC_PLL] && st_ff.ctl.oscEn[SRC_PLL]) begin
      nxt_st.pllFailFlag = 1'b1;
      fail = st_ff.monEn && (st_ff.ctl.sysSel == SRC_PLL
                             || st_ff.tgt == SRC_PLL);
      nxt_st.tk.nmi = nxt_st.tk.nmi || st_ff.monEn;
    end
    if (rise[IN_XFAIL] && st_ff.ctl.oscEn[SRC_XOSC]) begin
      nxt_st.xFailFlag = 1'b1;
      fail = fail || (st_ff.monEn && (st_ff.ctl.sysSel == SRC_XOSC
             || st_ff.tgt == SRC_XOSC || (st_ff.ctl.sysSel == SRC_PLL
             && st_ff.ctl.pllSrc == PLLSRC_XOSC)));
      nxt_st.tk.nmi = nxt_st.tk.nmi || st_ff.monEn;
    end
    // forced fall back overrides any switch in progress
    if (fail) begin
      nxt_st.req = SRC_RC2M;
      nxt_st.tgt = SRC_RC2M;
      nxt_st.ctl.oscEn[SRC_RC2M] = 1'b1;
      nxt_st.fallback = 1'b1;
      nxt_st.fsm = SW_STOP;
      nxt_st.ctl.clkHold = 1'b1;
      nxt_st.gapCnt = 3'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign axiRsp = st_ff.rsp;
  assign oscCtl = st_ff.ctl;
  assign ticks = st_ff.tk;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_reset_sources;
    $past(!rst_n) |-> st_ff.ctl.ulpEn && st_ff.ctl.oscEn[5:1] == 5'h00;
  endproperty
  a_reset_sources: assert property (p_reset_sources)
    else $error("sources enabled after reset");

  property p_reset_rc2m;
    $past(!rst_n) |-> st_ff.ctl.sysSel == SRC_RC2M && st_ff.req == SRC_RC2M;
  endproperty
  a_reset_rc2m: assert property (p_reset_rc2m)
    else $error("system clock not on 2MHz after reset");

  property p_reset_off;
    $past(!rst_n) |-> !st_ff.dfllEn && !st_ff.ctl.oscEn[SRC_PLL];
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("loop or pll on after reset");

  property p_gated_switch;
    $changed(st_ff.ctl.sysSel) |-> st_ff.ctl.clkHold && $past(
      st_ff.ctl.clkHold, 4);
  endproperty
  a_gated_switch: assert property (p_gated_switch)
    else $error("select moved without gap");

  property p_stable_target;
    $rose(st_ff.ctl.clkHold) && !st_ff.fallback |-> $past(reqOk);
  endproperty
  a_stable_target: assert property (p_stable_target)
    else $error("switch to unready source");

  property p_fallback;
    rise[IN_XFAIL] && st_ff.monEn && st_ff.ctl.oscEn[SRC_XOSC]
      && st_ff.ctl.sysSel == SRC_XOSC
      |=> st_ff.tk.nmi ##[1:12] st_ff.ctl.sysSel == SRC_RC2M;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("no fall back after crystal failure");

  property p_lock_flag;
    rise[SRC_PLL] && st_ff.ctl.oscEn[SRC_PLL] |=> st_ff.lockFlag;
  endproperty
  a_lock_flag: assert property (p_lock_flag)
    else $error("pll lock not flagged");

  property p_ulp_auto;
    (st_ff.ctl.rtcSel == RTC_ULP1K || wdtUsesUlp) |=> st_ff.ctl.ulpEn;
  endproperty
  a_ulp_auto: assert property (p_ulp_auto)
    else $error("low power oscillator not enabled");

  property p_pll_factor;
    st_ff.ctl.pllFactor != 5'h00;
  endproperty
  a_pll_factor: assert property (p_pll_factor)
    else $error("pll factor zero");

  property p_fast_clocks;
    st_ff.tk.cpuEn |-> st_ff.tk.per2En && st_ff.tk.per4En;
  endproperty
  a_fast_clocks: assert property (p_fast_clocks)
    else $error("cpu tick without fast ticks");
endmodule
`default_nettype wire

/* File: pkg/scs_pkg.sv */
// constants, codes and carrier types of the system clock source control
package scs_pkg;
  // clock source codes, also the index into enable and ready vectors
  localparam int NSRC = 6;
  localparam logic [2:0] SRC_RC2M = 3'h0;
  localparam logic [2:0] SRC_RC32M = 3'h1;
  localparam logic [2:0] SRC_RC32K = 3'h2;
  localparam logic [2:0] SRC_XOSC = 3'h3;
  localparam logic [2:0] SRC_PLL = 3'h4;
  localparam logic [2:0] SRC_X32K = 3'h5;
  // real-time counter clock choices
  localparam logic [2:0] RTC_ULP1K = 3'h0;
  localparam logic [2:0] RTC_X32K = 3'h1;
  localparam logic [2:0] RTC_ULP32K = 3'h2;
  localparam logic [2:0] RTC_RC1K = 3'h3;
  localparam logic [2:0] RTC_RC32K = 3'h4;
  // pll reference choices
  localparam logic [1:0] PLLSRC_RC2M = 2'h0;
  localparam logic [1:0] PLLSRC_RC32M = 2'h1;
  localparam logic [1:0] PLLSRC_XOSC = 2'h2;
  // register byte offsets
  localparam logic [7:0] OFF_SYS = 8'h00;
  localparam logic [7:0] OFF_OSC = 8'h04;
  localparam logic [7:0] OFF_XOSC = 8'h08;
  localparam logic [7:0] OFF_PLL = 8'h0C;
  localparam logic [7:0] OFF_PRESC = 8'h10;
  localparam logic [7:0] OFF_RTC = 8'h14;
  localparam logic [7:0] OFF_FREQUENCY_LOCKED_CALIBRATOR = 8'h18;
  localparam logic [7:0] OFF_CAL = 8'h1C;
  localparam logic [7:0] OFF_FAIL = 8'h20;
  localparam logic [7:0] OFF_PR = 8'h24;
  // field positions
  localparam int SYS_ACT_LSB = 8;
  localparam int SYS_HOLD_BIT = 12;
  localparam int OSC_RDY_LSB = 8;
  localparam int OSC_ULP_BIT = 16;
  localparam int XOSC_EXT_BIT = 2;
  localparam int XOSC_LP_BIT = 3;
  localparam int PLL_SRC_LSB = 8;
  localparam int FREQUENCY_LOCKED_CALIBRATOR_REF_BIT = 1;
  localparam int FREQUENCY_LOCKED_CALIBRATOR_TGT_LSB = 8;
  localparam int CAL_32M_LSB = 8;
  localparam int CAL_32K_LSB = 16;
  localparam int FAIL_LNMI_BIT = 1;
  localparam int FAIL_XF_BIT = 8;
  localparam int FAIL_PF_BIT = 9;
  localparam int FAIL_LK_BIT = 10;
  // limits, reset values, timing counts
  localparam logic [3:0] DIV_EXP_MAX = 4'hB;
  localparam logic [4:0] PLL_FACTOR_RST = 5'h01;
  localparam logic [7:0] FREQUENCY_LOCKED_CALIBRATOR_TARGET_RST = 8'h3D;
  localparam logic [4:0] LF_DIV_LAST = 5'h1F;
  localparam logic [2:0] SWITCH_GAP_CYC = 3'h4;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // synchronised input bit positions
  localparam int IN_XFAIL = 6;
  localparam int IN_ULP = 7;
  localparam int IN_RC32K = 8;
  localparam int IN_RC2M = 9;
  localparam int IN_X32K = 10;
  localparam int IN_W = 11;

  typedef enum logic [1:0] {SW_IDLE, SW_STOP, SW_RESTART} scs_sw_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } scs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scs_axi_rsp_t;

  typedef struct packed {
    logic [5:0] oscEn;
    logic ulpEn;
    logic [2:0] sysSel;
    logic clkHold;
    logic [4:0] pllFactor;
    logic [1:0] pllSrc;
    logic [1:0] xoscRange;
    logic crystalInputExtClk;
    logic lowFreqCrystalLowPwr;
    logic [2:0] rtcSel;
    logic [6:0] cal2m;
    logic [6:0] cal32m;
    logic [7:0] cal32k;
    logic [7:0] periphClkEn;
  } scs_oscctl_t;

  typedef struct packed {
    logic per4En;
    logic per2En;
    logic cpuEn;
    logic ulp1k;
    logic ulp32k;
    logic rc32kOut;
    logic rc1kOut;
    logic nmi;
  } scs_ticks_t;
endpackage

/* File: tb/scs_osc_model.sv */
// oscillator, crystal and pll model on the far side of the clock control
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
  parameter int RDY_DLY = 20
) (
  input wire logic clk_sys,
  input wire logic [5:0] oscEn,
  input wire logic failCmd,
  output var logic [5:0] oscRdy,
  output var logic xoscFail,
  output var logic ulpTick,
  output var logic rc32kTick,
  output var logic rc2mTick,
  output var logic lowFreqCrystalTick
);
  int upCnt[6];
  logic [4:0] phase = 5'h00;
  initial oscRdy = 6'h00;
  // ready only after start-up; a failed crystal loses it at once
  always @(posedge clk_sys) begin
    phase <= phase + 5'h01;
    for (int i = 0; i < 6; i++) begin
      if (!oscEn[i] || (i == 3 && failCmd)) upCnt[i] <= 0;
      else if (upCnt[i] < RDY_DLY) upCnt[i] <= upCnt[i] + 1;
      oscRdy[i] <= (upCnt[i] == RDY_DLY);
    end
  end
  assign xoscFail = failCmd;
  // levels held at least two cycles so the sampler sees every edge
  assign rc2mTick = phase[1];
  assign ulpTick = phase[2];
  assign rc32kTick = phase[3];
  assign lowFreqCrystalTick = phase[4];
endmodule
`default_nettype wire

/* File: tb/system_clock_source_control_tb.sv */
// register-level tests of the system clock source control
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control_tb;
  import scs_pkg::*;
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  err_count++; $display("ERROR %s exp %0h got %0h", nm, ex, gt); end end
  localparam logic [6:0] C2M = 7'h40;
  localparam logic [6:0] C32M = 7'h40;
  localparam logic [7:0] C32K = 8'h80;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic failCmd = 1'b0;
  logic wdtUsesUlp = 1'b0;
  scs_axi_req_t axiReq = '0;
  scs_axi_rsp_t axiRsp;
  scs_oscctl_t oscCtl;
  scs_ticks_t ticks;
  logic [5:0] oscRdy;
  logic xoscFail, ulpTick, rc32kTick, rc2mTick, lfTick;
  logic [31:0] rdVal;
  logic [1:0] resp;
  int err_count = 0;
  int checks_done = 0;
  int nmiSeen = 0;
  int n;
  int tkCnt[8];
  logic [7:0] tkv;

  scs_clock_ctrl #(.CAL2M_PROD(C2M), .CAL32M_PROD(C32M),
    .CAL32K_PROD(C32K)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .axiReq(axiReq), .axiRsp(axiRsp), .oscRdy(oscRdy),
    .xoscFail(xoscFail), .ulpTick(ulpTick), .rc32kTick(rc32kTick),
    .rc2mTick(rc2mTick), .lowFreqCrystalTick(lfTick),
    .wdtUsesUlp(wdtUsesUlp), .oscCtl(oscCtl), .ticks(ticks));
  scs_osc_model #(.RDY_DLY(20)) osc (.clk_sys(clk_sys),
    .oscEn(oscCtl.oscEn), .failCmd(failCmd), .oscRdy(oscRdy),
    .xoscFail(xoscFail), .ulpTick(ulpTick), .rc32kTick(rc32kTick),
    .rc2mTick(rc2mTick), .lowFreqCrystalTick(lfTick));

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (ticks.nmi === 1'b1) nmiSeen++;
  assign tkv = ticks;
  always @(posedge clk_sys) begin
    for (int k = 1; k < 8; k++) if (tkv[k] === 1'b1) tkCnt[k]++;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk_sys);
      if (!awDone && axiRsp.awready === 1'b1) begin
        awDone = 1'b1;
        axiReq.awvalid <= 1'b0;
      end
      if (!wDone && axiRsp.wready === 1'b1) begin
        wDone = 1'b1;
        axiReq.wvalid <= 1'b0;
      end
    end
    while (axiRsp.bvalid !== 1'b1) @(posedge clk_sys);
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    // idle edge, so a following call never drives bready twice in one step
    @(posedge clk_sys);
  endtask

  task automatic rdr(input logic [7:0] a);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do @(posedge clk_sys); while (axiRsp.arready !== 1'b1);
    axiReq.arvalid <= 1'b0;
    do @(posedge clk_sys); while (axiRsp.rvalid !== 1'b1);
    rdVal = axiRsp.rdata;
    resp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // hold, gap, select, gap, release
  task automatic swchk(input logic [2:0] src);
    wr(OFF_SYS, {29'h0, src});
    while (oscCtl.clkHold !== 1'b1) @(posedge clk_sys);
    n = 0;
    do begin @(posedge clk_sys); n++; end while (oscCtl.sysSel !== src);
    `CHK("holdToSel", 3'(SWITCH_GAP_CYC), 3'(n))
    n = 0;
    do begin @(posedge clk_sys); n++; end while (oscCtl.clkHold !== 1'b0);
    `CHK("selToRun", 3'(SWITCH_GAP_CYC), 3'(n))
  endtask

  // tick pulses over 512 cycles at prescaler exponent e; tallied between
  // falling edges so clearing never races the counting process
  task automatic tkwin(input int e);
    @(negedge clk_sys);
    for (int k = 0; k < 8; k++) tkCnt[k] = 0;
    repeat (512) @(negedge clk_sys);
    `CHK("per4", 512 >> e, tkCnt[7])
    `CHK("per2", 256 >> e, tkCnt[6])
    `CHK("cpu", 128 >> e, tkCnt[5])
    `CHK("ulp32k", 64, tkCnt[3])
    `CHK("ulp1k", 2, tkCnt[4])
    `CHK("rc1k", 1, tkCnt[1])
    @(posedge clk_sys);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    `CHK("oscEn", 6'h01, oscCtl.oscEn)
    `CHK("sysSel", SRC_RC2M, oscCtl.sysSel)
    rdr(OFF_FREQUENCY_LOCKED_CALIBRATOR);
    `CHK("frequency_locked_calibrator", {16'h0, FREQUENCY_LOCKED_CALIBRATOR_TARGET_RST, 8'h00}, rdVal)
    rdr(OFF_CAL);
    `CHK("cal", {8'h0, C32K, 1'b0, C32M, 1'b0, C2M}, rdVal)
    wr(OFF_CAL, 32'h00AA1B2C);
    `CHK("cal32k", 8'hAA, oscCtl.cal32k)
    rdr(8'h28);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {resp, rdVal})
    wr(8'h28, 32'h1);
    `CHK("wrErr", RESP_SLVERR, resp)
    wr(OFF_XOSC, 32'h7);
    `CHK("xrange", 2'h3, oscCtl.xoscRange)
    `CHK("extClk", 1'b1, oscCtl.crystalInputExtClk)
    tkwin(0);
    $display("test reset and calibration done");
    wr(OFF_OSC, 32'h3);
    do rdr(OFF_OSC); while (rdVal[OSC_RDY_LSB + 1] !== 1'b1);
    swchk(SRC_RC32M);
    wr(OFF_SYS, {29'h0, SRC_PLL});
    repeat (30) @(posedge clk_sys);
    `CHK("keepSrc", SRC_RC32M, oscCtl.sysSel)
    $display("test source switch done");
    wr(OFF_PLL, 32'h0);
    `CHK("pllZero", 5'h01, oscCtl.pllFactor)
    wr(OFF_PLL, 32'h1F);
    `CHK("pllMax", 5'h1F, oscCtl.pllFactor)
    wr(OFF_PRESC, 32'hC);
    rdr(OFF_PRESC);
    `CHK("prescOver", 32'h0, rdVal)
    wr(OFF_PRESC, {28'h0, DIV_EXP_MAX});
    rdr(OFF_PRESC);
    `CHK("prescMax", {28'h0, DIV_EXP_MAX}, rdVal)
    wr(OFF_PRESC, 32'h2);
    wr(OFF_FREQUENCY_LOCKED_CALIBRATOR, 32'h3D01);
    tkwin(2);
    `CHK("dfllUp", 1'b1, oscCtl.cal2m > 7'h2C)
    for (int i = 0; i < 6; i++) begin
      wr(OFF_RTC, i);
      repeat (2) @(posedge clk_sys);
      `CHK("rtcSel", (i > 4) ? 3'h4 : 3'(i), oscCtl.rtcSel)
      `CHK("ulpEn", (i == 0 || i == 2), oscCtl.ulpEn)
    end
    wdtUsesUlp <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK("ulpWdt", 1'b1, oscCtl.ulpEn)
    wr(OFF_PR, 32'hA5);
    `CHK("periph", 8'h5A, oscCtl.periphClkEn)
    $display("test fields done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    `CHK("rstSel", SRC_RC2M, oscCtl.sysSel)
    `CHK("rstEn", 6'h01, oscCtl.oscEn)
    `CHK("rstPll", 5'h01, oscCtl.pllFactor)
    $display("test second reset done");
    wr(OFF_OSC, 32'h9);
    do rdr(OFF_OSC); while (rdVal[OSC_RDY_LSB + 3] !== 1'b1);
    swchk(SRC_XOSC);
    wr(OFF_FAIL, 32'h3);
    nmiSeen = 0;
    failCmd <= 1'b1;
    do @(posedge clk_sys); while (oscCtl.sysSel !== SRC_RC2M);
    `CHK("failNmi", 1, nmiSeen)
    rdr(OFF_FAIL);
    `CHK("failFlag", 1'b1, rdVal[FAIL_XF_BIT])
    failCmd <= 1'b0;
    wr(OFF_FAIL, 32'h103);
    rdr(OFF_FAIL);
    `CHK("failClr", 1'b0, rdVal[FAIL_XF_BIT])
    nmiSeen = 0;
    wr(OFF_OSC, 32'h11);
    do rdr(OFF_FAIL); while (rdVal[FAIL_LK_BIT] !== 1'b1);
    `CHK("lockNmi", 1, nmiSeen)
    $display("test failure and lock done");
    finish_test;
  end

  initial begin
    #(100 * 6000);
    err_count++;
    $display("watchdog expired");
    finish_test;
  end
`undef CHK
endmodule
`default_nettype wire
